// ==== sim/agac_chk.sv ====
// checker: gain programming, read-back and repeat-count event timing
`timescale 1ns/1ps
module agac_chk (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire agac_pkg::agac_sfr_req_t i_sfr,
    input wire logic i_multi_shot_mode,
    input wire agac_pkg::agac_core_t i_core,
    input wire logic [7:0] o_rdata,
    input wire logic o_core_start,
    input wire logic o_conversion_done_event,
    input wire logic o_window_compare_event,
    input wire agac_pkg::agac_gain_t o_gain
);
    import agac_pkg::*;
    logic [7:0] cfg_q, cfg_d, idx_q, idx_d;
    logic [4:0] dn_q, dn_d, exp_n;
    logic ld;
    assign ld = i_sfr.wr && i_sfr.addr == AGAC_RESL_ADDR;
    assign exp_n = (cfg_q[2:1] == 2'b00) ? 5'h01 : 5'h02 << cfg_q[2:1];
    always_comb begin
        cfg_d = cfg_q;
        idx_d = idx_q;
        dn_d = o_conversion_done_event ? 5'h00 : dn_q + {4'h0, i_core.done};
        if (i_sfr.wr && i_sfr.addr == AGAC_CFG_ADDR) cfg_d = i_sfr.wdata;
        if (i_sfr.wr && i_sfr.addr == AGAC_RESH_ADDR && cfg_q[0]) idx_d = i_sfr.wdata;
    end
    always_ff @(posedge i_clk_sys) begin
        cfg_q <= i_reset ? AGAC_CFG_RESET : cfg_d;
        idx_q <= i_reset ? 8'h00 : idx_d;
        dn_q <= i_reset ? 5'h00 : dn_d;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    a_gain_high_load: assert property (ld && cfg_q[0] && idx_q == AGAC_GNH_IADDR |=>
        o_gain.gain_code[11:4] == $past(i_sfr.wdata)) else $error("gain high not loaded");
    a_gain_add_load: assert property (ld && cfg_q[0] && idx_q == AGAC_GNA_IADDR |=>
        o_gain.gain_add == $past(i_sfr.wdata[0])) else $error("gain add not loaded");
    a_gain_locked: assert property (ld && !cfg_q[0] |=> $stable(o_gain))
        else $error("gain changed with programming off");
    a_gain_reset_value: assert property (disable iff (1'b0) i_reset |=>
        o_gain == {12'hFC0, 1'b1}) else $error("gain reset value wrong");
    a_cfg_read_back: assert property (i_sfr.rd && i_sfr.addr == AGAC_CFG_ADDR |=>
        o_rdata == $past(cfg_q)) else $error("config read-back wrong");
    a_done_after_count: assert property (o_conversion_done_event |->
        $past(i_core.done) && dn_q == exp_n) else $error("done event count wrong");
    a_win_with_done: assert property (o_window_compare_event |-> o_conversion_done_event)
        else $error("window event without done");
    a_burst_next_start: assert property (i_multi_shot_mode && i_core.done && dn_q + 5'h01 < exp_n
        |=> o_core_start) else $error("multi-shot did not continue");
    a_single_no_restart: assert property (!i_multi_shot_mode && i_core.done |=> !o_core_start [*3])
        else $error("self-start outside multi-shot");
    c_done: cover property (o_conversion_done_event);
    c_win: cover property (o_window_compare_event);
    c_gain: cover property (ld && cfg_q[0]);
endmodule : agac_chk

// ==== sim/agac_core_model.sv ====
// converter core stand-in: answers each start with a done pulse and a code
`timescale 1ns/1ps
module agac_core_model (
    input wire logic i_clk_sys,
    input wire logic i_start,
    input wire logic i_slow,
    input wire logic i_win_req,
    input wire logic [11:0] i_code,
    output agac_pkg::agac_core_t o_core
);
    import agac_pkg::*;
    int cnt = 0;
    initial o_core = '0;
    always @(posedge i_clk_sys) begin
        o_core.done <= 1'b0;
        o_core.win <= 1'b0;
        // code bus is not held outside done, so it keeps changing
        o_core.code <= ~o_core.code;
        if (i_start) begin
            cnt <= i_slow ? 24 : 3;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            o_core.done <= 1'b1;
            o_core.win <= i_win_req;
            o_core.code <= i_code;
        end
    end
endmodule : agac_core_model

// ==== sim/tb_top.sv ====
// testbench: register access, gain programming, sar clock and accumulation
`timescale 1ns/1ps
module tb_top;
    import agac_pkg::*;
    localparam logic [11:0] CODE = 12'hABC;
    logic i_clk_sys = 0, i_reset = 1, ms_clk = 0, ms = 0, cs = 0, wreq = 0, slow = 0;
    logic sar, cstart, done, win, last;
    logic [7:0] hi, lo;
    logic [15:0] seq [7] = '{16'hBC01, 16'hBE04, 16'hBD6C, 16'hBE07, 16'hBDA0, 16'hBE08, 16'hBD00};
    agac_sfr_req_t sfr = '0;
    agac_core_t core;
    agac_gain_t gain;
    logic [7:0] rdata;
    int err_count = 0, checked = 0, n_cv = 0, n_ev = 0, n_win = 0, cnt, k2;
    int p [3];
    initial forever #2.5 i_clk_sys = ~i_clk_sys;
    // 25 MHz multi-shot source, under its limit
    initial forever #20 ms_clk = ~ms_clk;
    agac_top u_agac_top (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(1'b1), .i_ms_clk(ms_clk),
        .i_sfr(sfr), .i_multi_shot_mode(ms), .i_convert_start(cs), .i_core(core), .o_rdata(rdata),
        .o_sar_clock(sar), .o_core_start(cstart), .o_conversion_done_event(done),
        .o_window_compare_event(win), .o_gain(gain));
    agac_core_model u_agac_core_model (.i_clk_sys(i_clk_sys), .i_start(cstart), .i_slow(slow),
        .i_win_req(wreq), .i_code(CODE), .o_core(core));
    always @(posedge i_clk_sys) begin
        n_cv <= n_cv + core.done;
        n_ev <= n_ev + done;
        n_win <= n_win + win;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        sfr = '{1'b1, 1'b0, a, d};
        @(negedge i_clk_sys);
        sfr = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk_sys);
        sfr = '{1'b0, 1'b1, a, 8'h00};
        @(negedge i_clk_sys);
        sfr = '0;
        @(negedge i_clk_sys);
        d = rdata;
    endtask : rd
    task automatic start();
        cs = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        cs = 1'b0;
        repeat (2) @(negedge i_clk_sys);
    endtask : start
    task automatic wait_cv(input int n);
        int g;
        g = 0;
        while (n_cv < n && g < 200) begin
            @(negedge i_clk_sys);
            g++;
        end
        repeat (3) @(negedge i_clk_sys);
    endtask : wait_cv
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (5) @(negedge i_clk_sys);
        i_reset = 0;
        rd(AGAC_CFG_ADDR, hi);
        chk("cfg_reset", 16'h00F8, {8'h00, hi});
        chk("gain_reset", 16'h1F81, 16'(gain));
        wr(AGAC_RESL_ADDR, 8'h55);
        chk("gain_locked", 16'h1F81, 16'(gain));
        foreach (seq[i]) wr(seq[i][15:8], seq[i][7:0]);
        chk("gain_loaded", 16'h0D94, 16'(gain));
        rd(AGAC_RESL_ADDR, lo);
        chk("gain_not_readable", 16'h0000, {8'h00, lo});
        rd(8'h80, lo);
        chk("unmapped_read", 16'h0000, {8'h00, lo});
        for (int r = 0; r < 4; r++) begin
            cnt = (r == 0) ? 1 : 2 << r;
            ms = (r > 1);
            wreq = (r == 2);
            // gain programming off before any start
            wr(AGAC_CFG_ADDR, {5'h01, r[1:0], 1'b0});
            n_cv = 0;
            n_ev = 0;
            n_win = 0;
            for (int k = 0; k < (ms ? 1 : cnt); k++) begin
                start();
                wait_cv(ms ? cnt : k + 1);
                if (k == cnt - 2) chk("early_event", 16'h0000, 16'(n_ev));
            end
            chk("done_event", 16'h0001, 16'(n_ev));
            chk("win_event", 16'(r == 2), 16'(n_win));
            rd(AGAC_RESH_ADDR, hi);
            rd(AGAC_RESL_ADDR, lo);
            // sum read right justified, high byte then low byte
            chk("accumulated", 16'(CODE * cnt), {hi, lo});
        end
        ms = 0;
        slow = 1;
        // 200 MHz source, 100 MHz sar limit: divider 1 after rounding up
        wr(AGAC_CFG_ADDR, 8'h08);
        n_cv = 0;
        p = '{0, 0, 0};
        k2 = 0;
        start();
        last = sar;
        for (int i = 0; i < 14; i++) begin
            @(negedge i_clk_sys);
            if (sar !== last && k2 < 3) begin
                p[k2] = i;
                k2++;
            end
            last = sar;
        end
        // one sar period is div+1 source cycles
        chk("sar_period", 16'h0002, 16'(p[2] - p[0]));
        wait_cv(1);
        print_verdict();
    end
endmodule : tb_top
bind agac_top agac_chk u_agac_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_sfr(i_sfr),
    .i_multi_shot_mode(i_multi_shot_mode), .i_core(i_core), .o_rdata(o_rdata), .o_core_start(o_core_start),
    .o_conversion_done_event(o_conversion_done_event), .o_window_compare_event(o_window_compare_event),
    .o_gain(o_gain));

// ==== src/agac_clkdiv.sv ====
// sar clock divider producing a one-cycle tick per sar period
`timescale 1ns/1ps
module agac_clkdiv (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_run,
    input wire logic [4:0] i_div,
    output logic o_tick
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic tick_q;
    logic tick_d;

    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!i_run) begin
            cnt_d = 5'h00;
        end else if (cnt_q >= i_div) begin
            cnt_d = 5'h00;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 5'h01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cnt_q <= 5'h00;
            tick_q <= 1'b0;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;
endmodule : agac_clkdiv

// ==== src/agac_pkg.sv ====
// package: constants and carrier types for the converter gain and accumulate configuration
package agac_pkg;
    localparam logic [7:0] AGAC_CFG_ADDR = 8'hBC;
    localparam logic [7:0] AGAC_RESH_ADDR = 8'hBE;
    localparam logic [7:0] AGAC_RESL_ADDR = 8'hBD;
    localparam logic [7:0] AGAC_GNH_IADDR = 8'h04;
    localparam logic [7:0] AGAC_GNL_IADDR = 8'h07;
    localparam logic [7:0] AGAC_GNA_IADDR = 8'h08;
    localparam logic [7:0] AGAC_CFG_RESET = 8'hF8;
    localparam logic [7:0] AGAC_GNH_RESET = 8'hFC;
    localparam logic [3:0] AGAC_GNL_RESET = 4'h0;
    localparam logic AGAC_GNA_RESET = 1'b1;
    localparam int AGAC_DIV_MSB = 7;
    localparam int AGAC_DIV_LSB = 3;
    localparam int AGAC_RPT_MSB = 2;
    localparam int AGAC_RPT_LSB = 1;
    localparam int AGAC_GEN_BIT = 0;
    localparam int AGAC_GNL_MSB = 7;
    localparam int AGAC_GNL_LSB = 4;
    localparam int AGAC_GNA_BIT = 0;
    // multi-shot source limit, in MHz
    localparam int AGAC_MS_CLK_MAX_MHZ = 30;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } agac_sfr_req_t;

    typedef struct packed {
        logic start;
        logic done;
        logic win;
        logic [11:0] code;
    } agac_core_t;

    // effective gain with 13 bits below the point: gain_code*2 + add*128 over 8192
    typedef struct packed {
        logic [11:0] gain_code;
        logic gain_add;
    } agac_gain_t;

    typedef enum logic [2:0] {
        AGAC_IDLE = 3'b001,
        AGAC_CONV = 3'b010,
        AGAC_WAIT = 3'b100
    } agac_state_t;

    function automatic logic [4:0] agac_rpt_count(input logic [1:0] f);
        case (f)
            2'b00: agac_rpt_count = 5'h01;
            2'b01: agac_rpt_count = 5'h04;
            2'b10: agac_rpt_count = 5'h08;
            default: agac_rpt_count = 5'h10;
        endcase
    endfunction : agac_rpt_count
endpackage : agac_pkg

// ==== src/agac_top.sv ====
// gain programming, sar clock selection and repeat accumulation control
`timescale 1ns/1ps
module agac_top (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_ms_clk,
    input wire agac_pkg::agac_sfr_req_t i_sfr,
    input wire logic i_multi_shot_mode,
    input wire logic i_convert_start,
    input wire agac_pkg::agac_core_t i_core,
    output logic [7:0] o_rdata,
    output logic o_sar_clock,
    output logic o_core_start,
    output logic o_conversion_done_event,
    output logic o_window_compare_event,
    output agac_pkg::agac_gain_t o_gain
);
    import agac_pkg::*;

    logic [7:0] cfg_q, cfg_d;
    logic [7:0] iaddr_q, iaddr_d;
    logic [7:0] gnh_q, gnh_d;
    logic [3:0] gnl_q, gnl_d;
    logic gna_q, gna_d;
    logic [15:0] acc_q, acc_d;
    logic [4:0] left_q, left_d;
    logic win_q, win_d;
    agac_state_t st_q, st_d;
    logic start_q, start_d;
    logic done_q, done_d;
    logic wev_q, wev_d;
    logic [7:0] rdata_q, rdata_d;
    logic ms_s1_q, ms_s2_q, ms_s3_q;
    logic mc_s1_q, mc_s2_q, mc_s3_q;
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic sar_q, sar_d;
    logic tick;
    logic gen;
    logic [4:0] div;
    logic cs_rise;
    logic mc_rise;
    logic div_ce;

    assign gen = cfg_q[AGAC_GEN_BIT];
    assign div = cfg_q[AGAC_DIV_MSB:AGAC_DIV_LSB];
    assign cs_rise = cs_s2_q & ~cs_s3_q;
    assign mc_rise = mc_s2_q & ~mc_s3_q;
    // multi-shot source steps the divider only on its own rising edges
    assign div_ce = i_ce & (~ms_s2_q | mc_rise);

    // divider on the selected source; restarts at a switch back to the system clock so the first period is whole, not at a switch to the multi-shot source
    agac_clkdiv u_div (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_ce(div_ce),
        .i_run(~(ms_s2_q ^ ms_s3_q)),
        .i_div(div),
        .o_tick(tick)
    );

    // register file and indirect gain access
    always_comb begin
        cfg_d = cfg_q;
        iaddr_d = iaddr_q;
        gnh_d = gnh_q;
        gnl_d = gnl_q;
        gna_d = gna_q;
        rdata_d = rdata_q;
        if (i_sfr.wr) begin
            if (i_sfr.addr == AGAC_CFG_ADDR) begin
                cfg_d = i_sfr.wdata;
            end else if (i_sfr.addr == AGAC_RESH_ADDR && gen) begin
                iaddr_d = i_sfr.wdata;
            end else if (i_sfr.addr == AGAC_RESL_ADDR && gen) begin
                if (iaddr_q == AGAC_GNH_IADDR) begin
                    gnh_d = i_sfr.wdata;
                end else if (iaddr_q == AGAC_GNL_IADDR) begin
                    gnl_d = i_sfr.wdata[AGAC_GNL_MSB:AGAC_GNL_LSB];
                end else if (iaddr_q == AGAC_GNA_IADDR) begin
                    gna_d = i_sfr.wdata[AGAC_GNA_BIT];
                end
            end
        end
        // gain registers never read back; result reads return the sum
        if (i_sfr.rd) begin
            if (i_sfr.addr == AGAC_CFG_ADDR) begin
                rdata_d = cfg_q;
            end else if (i_sfr.addr == AGAC_RESH_ADDR) begin
                rdata_d = acc_q[15:8];
            end else if (i_sfr.addr == AGAC_RESL_ADDR) begin
                rdata_d = acc_q[7:0];
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // accumulation sequencer
    always_comb begin
        st_d = st_q;
        acc_d = acc_q;
        left_d = left_q;
        win_d = win_q;
        start_d = 1'b0;
        done_d = 1'b0;
        wev_d = 1'b0;
        case (st_q)
            AGAC_IDLE: begin
                if (cs_rise && !gen) begin
                    acc_d = 16'h0000;
                    win_d = 1'b0;
                    left_d = agac_rpt_count(cfg_q[AGAC_RPT_MSB:AGAC_RPT_LSB]);
                    start_d = 1'b1;
                    st_d = AGAC_CONV;
                end
            end
            AGAC_CONV: begin
                if (i_core.done) begin
                    acc_d = acc_q + {4'h0, i_core.code};
                    win_d = win_q | i_core.win;
                    left_d = left_q - 5'h01;
                    if (left_q == 5'h01) begin
                        done_d = 1'b1;
                        wev_d = win_q | i_core.win;
                        st_d = AGAC_IDLE;
                    end else if (ms_s2_q) begin
                        start_d = 1'b1;
                    end else begin
                        st_d = AGAC_WAIT;
                    end
                end
            end
            AGAC_WAIT: begin
                if (ms_s2_q || cs_rise) begin
                    start_d = 1'b1;
                    st_d = AGAC_CONV;
                end
            end
            default: st_d = AGAC_IDLE;
        endcase
    end

    // pulse clock: one source period high every div+1
    // limitation: a zero field gives a steady high, no flop runs at the source rate
    always_comb begin
        sar_d = tick;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cfg_q <= AGAC_CFG_RESET;
            iaddr_q <= 8'h00;
            gnh_q <= AGAC_GNH_RESET;
            gnl_q <= AGAC_GNL_RESET;
            gna_q <= AGAC_GNA_RESET;
            rdata_q <= 8'h00;
            st_q <= AGAC_IDLE;
            acc_q <= 16'h0000;
            left_q <= 5'h00;
            win_q <= 1'b0;
            start_q <= 1'b0;
            done_q <= 1'b0;
            wev_q <= 1'b0;
            ms_s1_q <= 1'b0;
            ms_s2_q <= 1'b0;
            ms_s3_q <= 1'b0;
            mc_s1_q <= 1'b0;
            mc_s2_q <= 1'b0;
            mc_s3_q <= 1'b0;
            cs_s1_q <= 1'b0;
            cs_s2_q <= 1'b0;
            cs_s3_q <= 1'b0;
            sar_q <= 1'b0;
        end else if (i_ce) begin
            cfg_q <= cfg_d;
            iaddr_q <= iaddr_d;
            gnh_q <= gnh_d;
            gnl_q <= gnl_d;
            gna_q <= gna_d;
            rdata_q <= rdata_d;
            st_q <= st_d;
            acc_q <= acc_d;
            left_q <= left_d;
            win_q <= win_d;
            start_q <= start_d;
            done_q <= done_d;
            wev_q <= wev_d;
            // mode and multi-shot clock come from outside: two stages first
            ms_s1_q <= i_multi_shot_mode;
            ms_s2_q <= ms_s1_q;
            ms_s3_q <= ms_s2_q;
            mc_s1_q <= i_ms_clk;
            mc_s2_q <= mc_s1_q;
            mc_s3_q <= mc_s2_q;
            cs_s1_q <= i_convert_start;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            sar_q <= sar_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_sar_clock = sar_q;
    assign o_core_start = start_q;
    assign o_conversion_done_event = done_q;
    assign o_window_compare_event = wev_q;
    // gain code and add flag to the core
    assign o_gain = '{gain_code: {gnh_q, gnl_q}, gain_add: gna_q};
endmodule : agac_top
